/* File: hw/xlate_req_map.svh */
`ifndef XLATE_REQ_MAP_SVH
`define XLATE_REQ_MAP_SVH

// ************************************************************
// Register byte offsets (low word, high word)
// ************************************************************
`define XR_S1UR_LO      8'h00
`define XR_S1UR_HI      8'h04
`define XR_S1UW_LO      8'h08
`define XR_S1UW_HI      8'h0C
`define XR_S12PR_LO     8'h10
`define XR_S12PR_HI     8'h14
`define XR_AL_S1UR_LO   8'h20
`define XR_AL_S1UR_HI   8'h24
`define XR_AL_S1UW_LO   8'h28
`define XR_AL_S1UW_HI   8'h2C
`define XR_AL_S12PR_LO  8'h30
`define XR_AL_S12PR_HI  8'h34
`define XR_RESULT_LO    8'h40
`define XR_RESULT_HI    8'h44
`define XR_STATUS       8'h48

// ************************************************************
// Field positions
// ************************************************************
`define XR_ADDR_LSB     12
`define XR_ADDR_MSB     63
`define XR_ADDR_MSB_V1  31
`define XR_BANK_MSB     7
`define XR_RSV_MSB      11
`define XR_RSV_LSB      8
`define XR_ST_BUSY      0
`define XR_ST_COPY      1

// ************************************************************
// Reset values
// ************************************************************
`define XR_RESULT_RST   64'h0000_0000_0000_0000
`define XR_ADDR_RST     52'h0_0000_0000_0000
`define XR_BANK_RST     8'h00

`endif

/* File: hw/xlate_req_pkg.sv */
package xlate_req_pkg;

    // Access type that a request register stands for
    typedef enum logic [1:0] {
        KIND_S1_UR,
        KIND_S1_UW,
        KIND_S12_PR
    } kind_t;

endpackage

/* File: hw/xlate_req_regs.sv */
// Summary of operation
// RULE_01: Request registers are 64-bit write-only
// RULE_02: Low-word write zero-extends to 64 bits
// RULE_03: High-word write is ignored
// RULE_04: User-read takes address bits 63:12
// RULE_05: User-write request translates as unprivileged write
// RULE_06: Stage 1+2 request translates as privileged read
// RULE_07: Bank index bits 7:0; 11:8 reserved
// RULE_08: Writing a request starts translation
// RULE_09: Outcome lands in the result register
// RULE_10: Access security state picks register copy
// RULE_11: Secure copy only with two security states
// RULE_12: Secure alias reaches non-secure copy
// RULE_13: Older version: 32-bit, address bits 31:12
// RULE_14: Request registers optional in newer version
// RULE_15: Reserved bits ignored; reads lack side effects
`timescale 1ns/1ps
`include "xlate_req_map.svh"

module xlate_req_regs #(
    parameter bit TWO_SEC    = 1'b1,
    parameter bit V2_ARCH    = 1'b1,
    parameter bit XLATE_IMPL = 1'b1
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    input  wire logic [2:0]  pprot,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             xlate_req_valid,
    output logic [51:0]      xlate_addr,
    output logic [7:0]       xlate_bank_idx,
    output logic             xlate_priv,
    output logic             xlate_write,
    output logic             xlate_stage2,
    output logic             xlate_secure,
    input  wire logic        xlate_done,
    input  wire logic [63:0] xlate_result
);

    // ********************************************************
    // Declarations
    // ********************************************************
    logic                 pready_r;
    logic [31:0]          prdata_r;
    logic                 pslverr_r;
    logic                 valid_r;
    logic [51:0]          addr_r;
    logic [7:0]           bank_idx_r;
    logic                 priv_r;
    logic                 write_r;
    logic                 stage2_r;
    logic                 secure_r;
    logic                 busy_r;
    logic                 copy_r;
    logic [63:0]          result_r [2];

    logic                 secure_acc;
    logic                 copy_sel;
    logic                 is_req;
    logic                 is_lo;
    logic                 is_alias;
    logic                 mapped;
    logic                 wr_ignore;
    logic [31:0]          rd_val;
    xlate_req_pkg::kind_t kind;
    logic                 req_copy;
    logic                 wr_req;
    logic                 blk;
    logic                 done;
    logic                 launch;
    logic [63:0]          req_word;
    logic [51:0]          req_addr;

    // ********************************************************
    // Security state of the access
    // ********************************************************
    // Without two security states every access maps to copy 0
    assign secure_acc = TWO_SEC && !pprot[1];
    assign copy_sel   = secure_acc; // RULE_10 RULE_11

    // ********************************************************
    // Address decode
    // ********************************************************
    always_comb begin
        is_req   = 1'b0;
        is_lo    = 1'b0;
        is_alias = 1'b0;
        mapped   = 1'b1;
        kind     = xlate_req_pkg::KIND_S1_UR;
        rd_val   = 32'h0000_0000;
        case (paddr)
            `XR_S1UR_LO, `XR_S1UR_HI: begin
                is_req = 1'b1;
                kind   = xlate_req_pkg::KIND_S1_UR;
            end
            `XR_S1UW_LO, `XR_S1UW_HI: begin
                is_req = 1'b1;
                kind   = xlate_req_pkg::KIND_S1_UW;
            end
            `XR_S12PR_LO, `XR_S12PR_HI: begin
                is_req = 1'b1;
                kind   = xlate_req_pkg::KIND_S12_PR;
            end
            `XR_AL_S1UR_LO, `XR_AL_S1UR_HI: begin
                is_req   = 1'b1;
                is_alias = 1'b1;
                kind     = xlate_req_pkg::KIND_S1_UR;
            end
            `XR_AL_S1UW_LO, `XR_AL_S1UW_HI: begin
                is_req   = 1'b1;
                is_alias = 1'b1;
                kind     = xlate_req_pkg::KIND_S1_UW;
            end
            `XR_AL_S12PR_LO, `XR_AL_S12PR_HI: begin
                is_req   = 1'b1;
                is_alias = 1'b1;
                kind     = xlate_req_pkg::KIND_S12_PR;
            end
            `XR_RESULT_LO: begin
                rd_val = result_r[copy_sel][31:0];
            end
            `XR_RESULT_HI: begin
                rd_val = result_r[copy_sel][63:32];
            end
            `XR_STATUS: begin
                rd_val[`XR_ST_BUSY] = busy_r;
                rd_val[`XR_ST_COPY] = copy_r;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
        is_lo = !paddr[2];
        // Optional block: absent request registers decode as holes
        if (is_req && !XLATE_IMPL) begin // RULE_14
            mapped = 1'b0;
        end
        // Older version has no upper word in the request registers
        if (is_req && !is_lo && !V2_ARCH) begin // RULE_13
            mapped = 1'b0;
        end
        // Alias exists only with two security states
        if (is_alias && !TWO_SEC) begin // RULE_12
            mapped = 1'b0;
        end
    end

    // Non-secure access to an alias, upper-word write, or a
    // partial write is dropped; it gets an error response only where the address decodes as a hole
    assign wr_ignore = !is_lo // RULE_03
                    || (is_alias && !secure_acc)
                    || (pstrb != 4'hF);

    // Secure alias steers to the non-secure copy
    assign req_copy = is_alias ? 1'b0 : copy_sel; // RULE_12

    assign wr_req = psel && pwrite && is_req && mapped && !wr_ignore;

    // ********************************************************
    // Request word assembly
    // ********************************************************
    // Low-word write zero-extends; reserved bits drop out
    assign req_word = {32'h0000_0000, pwdata}; // RULE_02 RULE_01

    // Older version keeps only bits 31:12 of the address
    assign req_addr = V2_ARCH
        ? req_word[`XR_ADDR_MSB:`XR_ADDR_LSB] // RULE_04
        : {32'h0000_0000,
           req_word[`XR_ADDR_MSB_V1:`XR_ADDR_LSB]}; // RULE_13

    // ********************************************************
    // APB handshake
    // ********************************************************
    // A new request stalls the bus while one is in flight, so
    // no request is ever lost behind a running walk
    assign blk    = wr_req && busy_r;
    assign done   = psel && penable && pready_r;
    assign launch = done && wr_req; // RULE_08
    // Result and status writes finish normally and change
    // nothing, so software probing them sees no error

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= psel && penable && !pready_r && !blk;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (psel && penable && !pready_r && !blk) begin
            pslverr_r <= !mapped;
            // Request registers read as zero, no side effect
            prdata_r  <= (pwrite || !mapped) ? 32'h0000_0000
                                              : rd_val; // RULE_15
        end else begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
    end

    // ********************************************************
    // Translation request launch
    // ********************************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            valid_r <= 1'b0;
        end else begin
            valid_r <= launch; // RULE_08
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            addr_r   <= `XR_ADDR_RST;
            bank_idx_r <= `XR_BANK_RST;
            priv_r   <= 1'b0;
            write_r  <= 1'b0;
            stage2_r <= 1'b0;
            secure_r <= 1'b0;
        end else if (launch) begin
            addr_r   <= req_addr; // RULE_04
            bank_idx_r <= req_word[`XR_BANK_MSB:0]; // RULE_07 RULE_15
            secure_r <= req_copy; // RULE_10
            case (kind)
                xlate_req_pkg::KIND_S1_UR: begin
                    priv_r   <= 1'b0; // RULE_04
                    write_r  <= 1'b0;
                    stage2_r <= 1'b0;
                end
                xlate_req_pkg::KIND_S1_UW: begin
                    priv_r   <= 1'b0; // RULE_05
                    write_r  <= 1'b1;
                    stage2_r <= 1'b0;
                end
                xlate_req_pkg::KIND_S12_PR: begin
                    priv_r   <= 1'b1; // RULE_06
                    write_r  <= 1'b0;
                    stage2_r <= 1'b1;
                end
                default: begin
                    priv_r   <= 1'b0;
                    write_r  <= 1'b0;
                    stage2_r <= 1'b0;
                end
            endcase
        end
    end

    // ********************************************************
    // Busy tracking and result capture
    // ********************************************************
    // Launch only happens while idle and completion only while
    // busy, so set and clear never meet in one cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            copy_r <= 1'b0;
        end else if (launch) begin
            busy_r <= 1'b1;
            copy_r <= req_copy;
        end else if (xlate_done) begin
            busy_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            result_r[0] <= `XR_RESULT_RST;
            result_r[1] <= `XR_RESULT_RST;
        end else if (busy_r && xlate_done) begin
            result_r[copy_r] <= xlate_result; // RULE_09 RULE_11
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign pready          = pready_r;
    assign prdata          = prdata_r;
    assign pslverr         = pslverr_r;
    assign xlate_req_valid = valid_r;
    assign xlate_addr      = addr_r;
    assign xlate_bank_idx  = bank_idx_r;
    assign xlate_priv      = priv_r;
    assign xlate_write     = write_r;
    assign xlate_stage2    = stage2_r;
    assign xlate_secure    = secure_r;

endmodule

/* File: sim/xlate_req_regs_sva.sv */
`timescale 1ns/1ps
`include "xlate_req_map.svh"
module xlate_req_regs_sva (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [2:0]  pprot,
    input wire logic        pready,
    input wire logic        xlate_req_valid,
    input wire logic [51:0] xlate_addr,
    input wire logic [7:0]  xlate_bank_idx,
    input wire logic        xlate_priv,
    input wire logic        xlate_write,
    input wire logic        xlate_stage2,
    input wire logic        xlate_secure
);
    // ************************************************************
    // Request launch relations
    // ************************************************************
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_start_on_write: assert property (
        xlate_req_valid |-> $past(pready && pwrite)) else $error("bad launch");
    a_valid_pulse: assert property (
        xlate_req_valid |=> !xlate_req_valid) else $error("long pulse");
    a_upper_ignored: assert property (
        pready && pwrite && paddr[2] |=> !xlate_req_valid)
        else $error("upper write launched");
    a_addr_zero_ext: assert property (
        xlate_req_valid |-> xlate_addr == {32'h0, $past(pwdata[31:12])})
        else $error("address not zero extended");
    a_bank_index: assert property (
        xlate_req_valid |-> xlate_bank_idx == $past(pwdata[7:0]))
        else $error("bank index wrong");
    a_user_read: assert property (
        xlate_req_valid && $past(paddr) == `XR_S1UR_LO
        |-> {xlate_priv, xlate_write, xlate_stage2} == 3'h0)
        else $error("user read attributes wrong");
    a_user_write: assert property (
        xlate_req_valid && $past(paddr) == `XR_S1UW_LO
        |-> {xlate_priv, xlate_write, xlate_stage2} == 3'h2)
        else $error("user write attributes wrong");
    a_priv_read: assert property (
        xlate_req_valid && $past(paddr) == `XR_S12PR_LO
        |-> {xlate_priv, xlate_write, xlate_stage2} == 3'h5)
        else $error("privileged read attributes wrong");
    a_secure_copy: assert property (
        xlate_req_valid |-> xlate_secure ==
        ($past(paddr) < 8'h20 && !$past(pprot[1]))) else $error("copy wrong");
endmodule

bind xlate_req_regs xlate_req_regs_sva u_sva (
    .mclk(mclk), .rst_n(rst_n), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pprot(pprot), .pready(pready),
    .xlate_req_valid(xlate_req_valid), .xlate_addr(xlate_addr),
    .xlate_bank_idx(xlate_bank_idx), .xlate_priv(xlate_priv),
    .xlate_write(xlate_write), .xlate_stage2(xlate_stage2),
    .xlate_secure(xlate_secure)
);

/* File: sim/global_addr_translate_request_regs_bench.sv */
`timescale 1ns/1ps
`include "xlate_req_map.svh"
module global_addr_translate_request_regs_bench;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        xlate_done = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic [2:0]  pprot = 3'h0;
    logic [63:0] xlate_result = 64'h0;
    logic        pready, pslverr, xlate_req_valid, xlate_priv, err;
    logic        xlate_write, xlate_stage2, xlate_secure;
    logic [31:0] prdata, rd;
    logic [51:0] xlate_addr;
    logic [7:0]  xlate_bank_idx;
    int          miscompares = 0;
    int          total_checks = 0;
    int          cycles = 0;

    xlate_req_regs DUT (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pprot(pprot), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .xlate_req_valid(xlate_req_valid), .xlate_addr(xlate_addr),
        .xlate_bank_idx(xlate_bank_idx), .xlate_priv(xlate_priv),
        .xlate_write(xlate_write), .xlate_stage2(xlate_stage2),
        .xlate_secure(xlate_secure), .xlate_done(xlate_done),
        .xlate_result(xlate_result)
    );

    always #5 mclk = ~mclk;

    // Whole run needs just over a hundred cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task report_and_stop;
        if (miscompares == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ************************************************************
    // Bus tasks
    // ************************************************************
    // One idle cycle after each transfer keeps psel from being driven
    // twice in one time step; the launch shows in that idle cycle
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d,
             input logic [2:0] p);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pprot <= p;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task req(input logic [7:0] a, input logic [31:0] d, input logic [2:0] p,
             input logic [2:0] attr, input logic s);
        apb(a, 1'b1, d, p);
        chk(xlate_req_valid, 1'b1);
        chk(xlate_addr, {32'h0, d[31:12]});
        chk(xlate_bank_idx, d[7:0]);
        chk({xlate_priv, xlate_write, xlate_stage2}, attr);
        chk(xlate_secure, s);
    endtask

    task finish_walk(input logic [63:0] r, input logic [2:0] p);
        xlate_done <= 1'b1;
        xlate_result <= r;
        @(posedge mclk);
        xlate_done <= 1'b0;
        apb(`XR_RESULT_LO, 1'b0, 32'h0, p);
        chk(rd, r[31:0]);
        apb(`XR_RESULT_HI, 1'b0, 32'h0, p);
        chk(rd, r[63:32]);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task t_kinds;
        req(`XR_S1UR_LO, 32'hFFFF_FFFF, 3'h0, 3'h0, 1'b1);
        finish_walk(64'h0123_4567_89AB_CDEF, 3'h0);
        req(`XR_S1UW_LO, 32'h0000_1A5C, 3'h0, 3'h2, 1'b1);
        finish_walk(64'hFEDC_BA98_7654_3210, 3'h0);
        req(`XR_S12PR_LO, 32'h8000_0F00, 3'h2, 3'h5, 1'b0);
        finish_walk(64'h5A5A_0000_A5A5_1111, 3'h2);
    endtask

    task t_alias;
        req(`XR_AL_S1UW_LO, 32'h1234_5601, 3'h0, 3'h2, 1'b0);
        finish_walk(64'h0000_7777_0000_8888, 3'h2);
        apb(`XR_AL_S12PR_LO, 1'b1, 32'hABCD_E0FF, 3'h2);
        chk(xlate_req_valid, 1'b0);
    endtask

    task t_ignored;
        apb(`XR_S1UR_HI, 1'b1, 32'hFFFF_F0FF, 3'h0);
        chk(xlate_req_valid, 1'b0);
        apb(`XR_S12PR_HI, 1'b1, 32'h0000_F001, 3'h2);
        chk(xlate_req_valid, 1'b0);
        pstrb <= 4'h3;
        apb(`XR_S1UW_LO, 1'b1, 32'h0000_5000, 3'h0);
        pstrb <= 4'hF;
        chk(xlate_req_valid, 1'b0);
        apb(`XR_S1UR_LO, 1'b0, 32'h0, 3'h0);
        chk(rd, 32'h0);
        chk(xlate_req_valid, 1'b0);
        apb(8'h50, 1'b0, 32'h0, 3'h0);
        chk(err, 1'b1);
    endtask

    task t_stall;
        req(`XR_S1UR_LO, 32'h0000_2003, 3'h0, 3'h0, 1'b1);
        apb(`XR_STATUS, 1'b0, 32'h0, 3'h0);
        chk(rd, 32'h0000_0003);
        fork
            req(`XR_S1UW_LO, 32'h0000_3004, 3'h0, 3'h2, 1'b1);
            begin
                repeat (6) @(posedge mclk);
                chk(pready, 1'b0);
                xlate_done <= 1'b1;
                @(posedge mclk);
                xlate_done <= 1'b0;
            end
        join
        finish_walk(64'h0000_0000_DEAD_0000, 3'h0);
    endtask

    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk(xlate_req_valid, 1'b0);
        t_kinds();
        t_alias();
        t_ignored();
        t_stall();
        report_and_stop();
    end
endmodule
